//--- card_socket_cycle_lane_steering_tb.sv
`timescale 1ns/1ns
module card_socket_cycle_lane_steering_tb;
    import cls_pkg::*;
    logic clk_i = 0, rst_i, valid, a0, tc, ready, done;
    cls_kind_e kind;
    cls_size_e size;
    logic [15:0] wd, cw, rdata, sd_o, sd_i;
    logic reg_n, ceh_n, cel_n, oe_n, we_n, ior_n, iow_n, dack, dreq;
    logic hi_oe, lo_oe, a0_pin;
    int miscompares, n_checks;

    always #2 clk_i = ~clk_i;

    cls_socket_steer #(.SETUP_CYC(2), .CMD_CYC(4), .REC_CYC(1)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(valid),
        .req_ready_o(ready), .req_kind_i(kind), .req_size_i(size),
        .req_addr0_i(a0), .req_wdata_i(wd), .req_tc_i(tc),
        .done_o(done), .rdata_o(rdata), .reg_n_o(reg_n),
        .card_high_byte_enable_n_o(ceh_n),
        .card_low_byte_enable_n_o(cel_n), .oe_n_o(oe_n), .we_n_o(we_n),
        .ior_n_o(ior_n), .iow_n_o(iow_n), .dack_o(dack), .dreq_o(dreq),
        .addr0_o(a0_pin), .sd_o(sd_o), .sd_hi_oe_o(hi_oe),
        .sd_lo_oe_o(lo_oe),
        .sd_i(sd_i));

    cls_card_model card_u (
        .clk_i(clk_i), .word_i(cw), .ceh_n_i(ceh_n), .cel_n_i(cel_n),
        .oe_n_i(oe_n), .ior_n_i(ior_n), .dack_i(dack), .addr0_i(a0_pin),
        .sd_o(sd_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [8:0] exp_pins(cls_kind_e k, cls_size_e s,
            logic t);
        logic [1:0] ce;
        logic d;
        d = k inside {CLS_DMA_M2IO, CLS_DMA_IO2M};
        ce = s == CLS_SZ_BYTE ? 2'b10 : (s == CLS_SZ_ODD && !d) ? 2'b01 :
            2'b00;
        case (k)
            CLS_ATTR_WR: exp_pins = {1'b0, ce, 6'b101100};
            CLS_MEM_RD: exp_pins = {1'b1, ce, 6'b011100};
            CLS_MEM_WR: exp_pins = {1'b1, ce, 6'b101100};
            CLS_IO_RD: exp_pins = {1'b0, ce, 6'b110100};
            CLS_IO_WR: exp_pins = {1'b0, ce, 6'b111000};
            CLS_DMA_M2IO: exp_pins = {1'b0, ce, 1'b1, ~t, 4'b1010};
            CLS_DMA_IO2M: exp_pins = {1'b0, ce, ~t, 1'b1, 4'b0110};
            default: exp_pins = {1'b0, ce, 6'b011100};
        endcase
    endfunction

    function automatic logic strobe_n(cls_kind_e k);
        case (k)
            CLS_ATTR_WR, CLS_MEM_WR: strobe_n = we_n;
            CLS_MEM_RD, CLS_ATTR_RD: strobe_n = oe_n;
            CLS_IO_RD, CLS_DMA_IO2M: strobe_n = ior_n;
            default: strobe_n = iow_n;
        endcase
    endfunction

    task automatic op(cls_kind_e k, cls_size_e s, logic a, logic [15:0] w,
            logic t, logic [15:0] c);
        int i;
        logic [8:0] pins, ep;
        logic lo_ok, hi_ok;
        logic [7:0] lo_v;
        logic [15:0] er;
        i = 0;
        while (ready !== 1'b1 && i < 200) begin
            @(negedge clk_i);
            i++;
        end
        kind = k; size = s; a0 = a; wd = w; tc = t; cw = c; valid = 1;
        @(negedge clk_i);
        valid = 0;
        for (i = 0; i < 100 && strobe_n(k) !== 1'b0; i++) @(negedge clk_i);
        pins = {reg_n, ceh_n, cel_n, oe_n, we_n, ior_n, iow_n, dack, dreq};
        ep = exp_pins(k, s, t);
        if (k inside {CLS_DMA_M2IO, CLS_DMA_IO2M}) begin
            pins[8] = 1'b0;
        end
        check(pins, ep);
        check(a0_pin, a);
        if (k inside {CLS_ATTR_WR, CLS_MEM_WR, CLS_IO_WR, CLS_DMA_M2IO}) begin
            hi_ok = k != CLS_ATTR_WR && s != CLS_SZ_BYTE;
            lo_ok = s == CLS_SZ_WORD || (s == CLS_SZ_ODD && k == CLS_DMA_M2IO)
                || (s == CLS_SZ_BYTE && !(k == CLS_ATTR_WR && a));
            lo_v = (s == CLS_SZ_BYTE && a && k != CLS_DMA_M2IO) ? w[15:8] :
                w[7:0];
            if (lo_ok) check({lo_oe, sd_o[7:0]}, {1'b1, lo_v});
            if (hi_ok) check({hi_oe, sd_o[15:8]}, {1'b1, w[15:8]});
        end else begin
            check({hi_oe, lo_oe}, 2'b00);
        end
        for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge clk_i);
        // A cycle that never ends counts as a mismatch
        if (done !== 1'b1) miscompares++;
        @(negedge clk_i);
        er = s == CLS_SZ_WORD ? c : s == CLS_SZ_ODD ? {c[15:8], 8'h00} :
            {8'h00, a ? c[15:8] : c[7:0]};
        if (k inside {CLS_MEM_RD, CLS_IO_RD}) check(rdata, er);
    endtask

    initial begin
        rst_i = 1; valid = 0; kind = CLS_ATTR_WR; size = CLS_SZ_BYTE;
        a0 = 0; wd = 0; tc = 0; cw = 0; miscompares = 0; n_checks = 0;
        void'($urandom(32'hBEEEBEC6));
        repeat (6) @(negedge clk_i);
        rst_i = 0;
        check(ready, 1'b1);
        for (int k = 0; k < 8; k++) begin
            for (int j = 0; j < 4; j++) begin
                op(cls_kind_e'(k), cls_size_e'(j < 2 ? 0 : j - 1), j[0],
                    16'hA55A ^ 16'(k), j[0], 16'h3CC3 + 16'(k));
            end
        end
        repeat (60) begin
            op(cls_kind_e'($urandom_range(7)), cls_size_e'($urandom_range(2)),
                1'($urandom_range(1)), 16'($urandom), 1'($urandom_range(1)),
                16'($urandom));
        end
        tally_and_finish;
    end

    // Whole run needs roughly 3 us; far beyond that means a hang
    initial begin
        #50000;
        miscompares++;
        tally_and_finish;
    end
endmodule

//--- cls_card_model.sv
`timescale 1ns/1ns
module cls_card_model
    import cls_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] word_i,
    input wire logic ceh_n_i,
    input wire logic cel_n_i,
    input wire logic oe_n_i,
    input wire logic ior_n_i,
    input wire logic dack_i,
    input wire logic addr0_i,
    output logic [15:0] sd_o
);
    logic [15:0] junk = 16'h0;
    logic rd;
    logic [7:0] lo;

    // Undriven lanes churn so a stale value never passes for data
    always_ff @(posedge clk_i) begin
        junk <= ~junk + 16'h1357;
    end

    always_comb begin
        // OE carries terminal count during DMA I/O to memory, so not a read then
        rd = (!oe_n_i && !dack_i) || !ior_n_i;
        // DMA byte transfers carry the even byte only
        lo = (addr0_i && ceh_n_i && !dack_i) ? word_i[15:8] : word_i[7:0];
        sd_o = junk;
        if (rd && !ceh_n_i) begin
            sd_o[15:8] = word_i[15:8];
        end
        if (rd && !cel_n_i) begin
            sd_o[7:0] = lo;
        end
    end
endmodule

//--- cls_lane_map.sv
`timescale 1ns/1ns
// Pure lane routing: which byte goes where, and which enables are asserted
module cls_lane_map
    import cls_pkg::*;
(
    input wire cls_pkg::cls_kind_e kind_i,
    input wire cls_pkg::cls_size_e size_i,
    input wire logic addr0_i,
    input wire logic [15:0] wdata_i,
    output logic ceh_n_o,
    output logic cel_n_o,
    output logic [15:0] lane_o,
    output logic lane_hi_oe_o,
    output logic lane_lo_oe_o,
    output logic hi_from_card_o,
    output logic lo_from_card_o
);
    logic is_write;
    always_comb begin
        is_write = (kind_i == CLS_ATTR_WR) || (kind_i == CLS_MEM_WR) ||
                   (kind_i == CLS_IO_WR) || (kind_i == CLS_DMA_M2IO);
        ceh_n_o = 1'b1;
        cel_n_o = 1'b0;
        lane_o = 16'h0000;
        lane_hi_oe_o = 1'b0;
        lane_lo_oe_o = 1'b0;
        hi_from_card_o = 1'b0;
        lo_from_card_o = 1'b0;
        case (size_i)
            CLS_SZ_WORD: begin
                ceh_n_o = 1'b0;
                cel_n_o = 1'b0;
            end
            CLS_SZ_ODD: begin
                ceh_n_o = 1'b0;
                cel_n_o = 1'b1;
            end
            default: begin
                ceh_n_o = 1'b1;
                cel_n_o = 1'b0;
            end
        endcase
        // DMA is byte or word only; an odd request falls back to word
        if ((kind_i == CLS_DMA_M2IO || kind_i == CLS_DMA_IO2M) &&
            size_i == CLS_SZ_ODD) begin
            ceh_n_o = 1'b0;
            cel_n_o = 1'b0;
        end
        if (is_write) begin
            if (kind_i == CLS_ATTR_WR) begin
                // Only the even byte matters; always lower lane
                lane_o = {8'h00, wdata_i[7:0]};
                lane_lo_oe_o = 1'b1;
            end else if (kind_i == CLS_DMA_M2IO) begin
                // DMA byte is always the even byte, whatever addr0 says
                if (size_i == CLS_SZ_BYTE) begin
                    lane_o = {8'h00, wdata_i[7:0]};
                end else begin
                    lane_o = wdata_i;
                    lane_hi_oe_o = 1'b1;
                end
                lane_lo_oe_o = 1'b1;
            end else if (size_i == CLS_SZ_WORD) begin
                lane_o = wdata_i;
                lane_hi_oe_o = 1'b1;
                lane_lo_oe_o = 1'b1;
            end else if (size_i == CLS_SZ_ODD) begin
                lane_o = {wdata_i[15:8], 8'h00};
                lane_hi_oe_o = 1'b1;
            end else begin
                lane_o = {8'h00, addr0_i ? wdata_i[15:8] : wdata_i[7:0]};
                lane_lo_oe_o = 1'b1;
            end
        end else if (kind_i == CLS_DMA_M2IO || kind_i == CLS_DMA_IO2M) begin
            // Card drives the low lane of a fly-by transfer, the high lane only when enabled
            hi_from_card_o = ~ceh_n_o;
            lo_from_card_o = 1'b1;
        end else begin
            hi_from_card_o = ~ceh_n_o;
            lo_from_card_o = ~cel_n_o;
        end
    end
endmodule

//--- cls_pkg.sv
package cls_pkg;
    // Access kinds requested of the socket lane steering
    typedef enum logic [2:0] {
        CLS_ATTR_WR,
        CLS_MEM_RD,
        CLS_MEM_WR,
        CLS_IO_RD,
        CLS_IO_WR,
        CLS_DMA_M2IO,
        CLS_DMA_IO2M,
        CLS_ATTR_RD
    } cls_kind_e;

    // Access widths
    typedef enum logic [1:0] {
        CLS_SZ_BYTE,
        CLS_SZ_WORD,
        CLS_SZ_ODD
    } cls_size_e;

    // Timing counts in 4 ns cycles
    localparam int CLS_CLK_NS = 4;
    localparam int CLS_SETUP_NS = 40;
    localparam int CLS_CMD_NS = 200;
    localparam int CLS_REC_NS = 40;
    localparam int CLS_SETUP_CYC = (CLS_SETUP_NS + CLS_CLK_NS - 1) / CLS_CLK_NS;
    localparam int CLS_CMD_CYC = (CLS_CMD_NS + CLS_CLK_NS - 1) / CLS_CLK_NS;
    localparam int CLS_REC_CYC = (CLS_REC_NS + CLS_CLK_NS - 1) / CLS_CLK_NS;
    localparam int CLS_CNT_W = 8;
endpackage

//--- cls_socket_steer.sv
`timescale 1ns/1ns
// What this block does
// - Attribute write: REG low, WE low, low lane
// - Attribute write carries only even byte, low lane
// - Memory byte read: low enable, byte on low lane
// - Memory word/odd read: odd byte on high lane
// - Memory byte write: address bit picks lower-lane byte
// - Memory word/odd write: odd byte on high lane
// - I/O read: REG low, IOR strobe, lane by size
// - I/O write: REG low, IOW strobe, lane by size
// - DMA memory to I/O: OE high, IOW, TC on WE
// - DMA I/O to memory: WE high, IOR, TC on OE
// - DMA memory to I/O lanes by width
// - DMA I/O to memory lanes by width
module cls_socket_steer
    import cls_pkg::*;
#(
    parameter int SETUP_CYC = CLS_SETUP_CYC,
    parameter int CMD_CYC = CLS_CMD_CYC,
    parameter int REC_CYC = CLS_REC_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire cls_pkg::cls_kind_e req_kind_i,
    input wire cls_pkg::cls_size_e req_size_i,
    input wire logic req_addr0_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic req_tc_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic reg_n_o,
    output logic card_high_byte_enable_n_o,
    output logic card_low_byte_enable_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic ior_n_o,
    output logic iow_n_o,
    output logic dack_o,
    output logic dreq_o,
    output logic addr0_o,
    output logic [15:0] sd_o,
    output logic sd_hi_oe_o,
    output logic sd_lo_oe_o,
    input wire logic [15:0] sd_i
);
    import cls_pkg::*;

    typedef enum logic [1:0] {
        CLS_ST_IDLE,
        CLS_ST_SETUP,
        CLS_ST_CMD,
        CLS_ST_REC
    } cls_state_e;

    typedef struct packed {
        cls_state_e st;
        logic [CLS_CNT_W-1:0] cnt;
        cls_kind_e kind;
        cls_size_e size;
        logic addr0;
        logic [15:0] wdata;
        logic tc;
        logic [15:0] sd_s1;
        logic [15:0] sd_s2;
        logic [15:0] rdata;
        logic done;
    } cls_state_s;

    cls_state_s s_reg;
    cls_state_s s_next;

    logic ceh_n;
    logic cel_n;
    logic [15:0] lane;
    logic hi_oe;
    logic lo_oe;
    logic hi_card;
    logic lo_card;
    logic active;
    logic strobe;

    function automatic logic [CLS_CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? CLS_CNT_W'(0) : CLS_CNT_W'(n - 1);
    endfunction

    cls_lane_map u_map (
        .kind_i(s_reg.kind),
        .size_i(s_reg.size),
        .addr0_i(s_reg.addr0),
        .wdata_i(s_reg.wdata),
        .ceh_n_o(ceh_n),
        .cel_n_o(cel_n),
        .lane_o(lane),
        .lane_hi_oe_o(hi_oe),
        .lane_lo_oe_o(lo_oe),
        .hi_from_card_o(hi_card),
        .lo_from_card_o(lo_card)
    );

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        // Pad data is asynchronous to us: two stages before capture
        s_next.sd_s1 = sd_i;
        s_next.sd_s2 = s_reg.sd_s1;
        case (s_reg.st)
            CLS_ST_IDLE: begin
                if (req_valid_i) begin
                    s_next.kind = req_kind_i;
                    s_next.size = req_size_i;
                    s_next.addr0 = req_addr0_i;
                    s_next.wdata = req_wdata_i;
                    s_next.tc = req_tc_i;
                    s_next.cnt = cyc(SETUP_CYC);
                    s_next.st = CLS_ST_SETUP;
                end
            end
            CLS_ST_SETUP: begin
                if (s_reg.cnt == '0) begin
                    s_next.cnt = cyc(CMD_CYC);
                    s_next.st = CLS_ST_CMD;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            CLS_ST_CMD: begin
                if (s_reg.cnt == '0) begin
                    // Sample at strobe end; sync latency hidden in pulse
                    s_next.rdata = {hi_card ? s_reg.sd_s2[15:8] : 8'h00,
                                    lo_card ? s_reg.sd_s2[7:0] : 8'h00};
                    s_next.done = 1'b1;
                    s_next.cnt = cyc(REC_CYC);
                    s_next.st = CLS_ST_REC;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            CLS_ST_REC: begin
                if (s_reg.cnt == '0) begin
                    s_next.st = CLS_ST_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            default: s_next.st = CLS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign active = (s_reg.st != CLS_ST_IDLE);
    assign strobe = (s_reg.st == CLS_ST_CMD);

    always_comb begin
        req_ready_o = ~active;
        done_o = s_reg.done;
        rdata_o = s_reg.rdata;
        addr0_o = s_reg.addr0;
        reg_n_o = 1'b1;
        card_high_byte_enable_n_o = 1'b1;
        card_low_byte_enable_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        ior_n_o = 1'b1;
        iow_n_o = 1'b1;
        dack_o = 1'b0;
        dreq_o = 1'b0;
        sd_o = 16'h0000;
        sd_hi_oe_o = 1'b0;
        sd_lo_oe_o = 1'b0;
        if (active) begin
            card_high_byte_enable_n_o = ceh_n;
            card_low_byte_enable_n_o = cel_n;
            sd_o = lane;
            sd_hi_oe_o = hi_oe;
            sd_lo_oe_o = lo_oe;
            case (s_reg.kind)
                CLS_ATTR_WR: begin
                    reg_n_o = 1'b0;
                    we_n_o = ~strobe;
                end
                CLS_ATTR_RD: begin
                    reg_n_o = 1'b0;
                    oe_n_o = ~strobe;
                end
                CLS_MEM_RD: oe_n_o = ~strobe;
                CLS_MEM_WR: we_n_o = ~strobe;
                CLS_IO_RD: begin
                    reg_n_o = 1'b0;
                    ior_n_o = ~strobe;
                end
                CLS_IO_WR: begin
                    reg_n_o = 1'b0;
                    iow_n_o = ~strobe;
                end
                CLS_DMA_M2IO: begin
                    dack_o = 1'b1;
                    we_n_o = ~s_reg.tc;
                    iow_n_o = ~strobe;
                end
                CLS_DMA_IO2M: begin
                    dack_o = 1'b1;
                    oe_n_o = ~s_reg.tc;
                    ior_n_o = ~strobe;
                end
                default: reg_n_o = 1'b1;
            endcase
        end
    end

    chk_enable_any: assert property (@(posedge clk_i) disable iff (rst_i)
        strobe |-> !(card_high_byte_enable_n_o && card_low_byte_enable_n_o))
        else $error("strobe with no card enable");
    chk_attr_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && s_reg.kind == CLS_ATTR_WR) |->
        (!reg_n_o && oe_n_o && !we_n_o && sd_lo_oe_o && !sd_hi_oe_o))
        else $error("attribute write pins wrong");
    chk_attr_even: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && s_reg.kind == CLS_ATTR_WR) |-> sd_o[7:0] == s_reg.wdata[7:0])
        else $error("attribute write lane wrong");
    chk_mem_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && s_reg.kind == CLS_MEM_RD && s_reg.size == CLS_SZ_BYTE) |->
        (reg_n_o && !oe_n_o && we_n_o && card_high_byte_enable_n_o &&
         !sd_hi_oe_o && !sd_lo_oe_o))
        else $error("memory byte read pins wrong");
    chk_odd_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && s_reg.kind == CLS_MEM_RD && s_reg.size == CLS_SZ_ODD) |->
        (!card_high_byte_enable_n_o && card_low_byte_enable_n_o))
        else $error("odd read enables wrong");
    chk_byte_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && s_reg.kind == CLS_MEM_WR && s_reg.size == CLS_SZ_BYTE) |->
        sd_o[7:0] == (s_reg.addr0 ? s_reg.wdata[15:8] : s_reg.wdata[7:0]))
        else $error("byte write lane wrong");
    chk_word_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (active && s_reg.kind == CLS_MEM_WR && s_reg.size == CLS_SZ_WORD) |->
        (sd_o == s_reg.wdata && sd_hi_oe_o && sd_lo_oe_o))
        else $error("word write lanes wrong");
    chk_io_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && s_reg.kind == CLS_IO_RD) |-> (!reg_n_o && !ior_n_o && iow_n_o))
        else $error("io read pins wrong");
    chk_io_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && s_reg.kind == CLS_IO_WR) |-> (!reg_n_o && ior_n_o && !iow_n_o))
        else $error("io write pins wrong");
    chk_dma_m2io: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && s_reg.kind == CLS_DMA_M2IO) |->
        (dack_o && !dreq_o && oe_n_o && ior_n_o && !iow_n_o &&
         we_n_o == !s_reg.tc))
        else $error("dma mem to io pins wrong");
    chk_dma_io2m: assert property (@(posedge clk_i) disable iff (rst_i)
        (strobe && s_reg.kind == CLS_DMA_IO2M) |->
        (dack_o && !dreq_o && oe_n_o == !s_reg.tc && we_n_o &&
         !ior_n_o && iow_n_o))
        else $error("dma io to mem pins wrong");
    chk_dma_word: assert property (@(posedge clk_i) disable iff (rst_i)
        (dack_o && s_reg.size == CLS_SZ_WORD) |->
        (!card_high_byte_enable_n_o && !card_low_byte_enable_n_o))
        else $error("dma word enables wrong");
    chk_cycle_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_valid_i && req_ready_o) |-> ##[1:300] done_o)
        else $error("cycle never completed");

    cov_mem_word: cover property (@(posedge clk_i) disable iff (rst_i)
        done_o && s_reg.kind == CLS_MEM_RD && s_reg.size == CLS_SZ_WORD);
    cov_io_write: cover property (@(posedge clk_i) disable iff (rst_i)
        done_o && s_reg.kind == CLS_IO_WR);
    cov_dma_tc: cover property (@(posedge clk_i) disable iff (rst_i)
        strobe && dack_o && s_reg.tc);
endmodule
